// ===== hw/opm_pkg.sv
// Package with register map, field layout and timing constants of the optical port modulator.
`default_nettype none
package opm_pkg;
   // ==========================================================================
   // Register map
   // ==========================================================================
   // Printed offsets are not multiples of four, so they are indices; byte address is four times the index.
   localparam logic [15:0] TX_CTRL_IDX   = 16'h2456;
   localparam logic [15:0] RXDUTY_IDX    = 16'h2457;
   localparam int          ADDR_W        = 18;
   localparam logic [7:0]  TX_CTRL_RST   = 8'h00;
   localparam logic [7:0]  RXDUTY_RST    = 8'h00;
   // Field positions.
   localparam int TXINV_BIT   = 0;
   localparam int TXMOD_BIT   = 1;
   localparam int TXSEL_LO    = 2;
   localparam int RXINV_BIT   = 1;
   localparam int DUTY_LO     = 4;
   localparam logic [1:0] TXSEL_SERIAL = 2'h0;
   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int CLK_HZ     = 200_000_000;
   localparam int CARRIER_HZ = 38_000;
   localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ;
   // Decoded control fields.
   typedef struct packed {
      logic [1:0] tx_sel;
      logic       tx_mod;
      logic       tx_inv;
      logic       rx_inv;
      logic [1:0] duty;
   } opm_ctrl_t;
endpackage
`default_nettype wire

// ===== hw/opm_top.sv
// Optical port modulator: pin select, polarity inversion and carrier gating of the second serial port.
//
// Our own choice: the Wishbone register port.
`default_nettype none
module opm_top #(
   parameter int CARRIER_CYCLES = opm_pkg::CARRIER_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [17:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        uart_tx_i,
   output logic             uart_rx_o,
   input  wire logic        sys_power_i,
   input  wire logic        brownout_battery_mode_i,
   output logic             optical_transmit_pin_o,
   output logic             optical_transmit_active_o,
   input  wire logic        optical_receive_pin_i
);
   // The carrier counter is 16 bits wide and the shortest low phase is one sixteenth of a period.
   if (CARRIER_CYCLES < 16 || CARRIER_CYCLES > 65535) begin : g_bad_carrier
      $error("CARRIER_CYCLES out of range");
   end

   // ==========================================================================
   // Wishbone slave
   // ==========================================================================
   logic [7:0]  tx_ctrl_q;
   logic [7:0]  rxduty_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   opm_pkg::opm_ctrl_t ctl;

   // Address decode; byte lane 0 carries the 8-bit registers.
   wire       req     = wb_cyc_i & wb_stb_i & ~ack_q;
   wire       hit_tx  = wb_adr_i == {opm_pkg::TX_CTRL_IDX, 2'b00};
   wire       hit_rx  = wb_adr_i == {opm_pkg::RXDUTY_IDX, 2'b00};
   wire       wr_lane = req & wb_we_i & wb_sel_i[0];
   wire [7:0] rd_byte = hit_tx ? tx_ctrl_q : (hit_rx ? rxduty_q : 8'h00);

   // Register writes and a one-cycle registered acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_ctrl_q <= opm_pkg::TX_CTRL_RST;
         rxduty_q  <= opm_pkg::RXDUTY_RST;
         ack_q     <= 1'b0;
         rdat_q    <= 32'h0000_0000;
      end else begin
         ack_q  <= req;
         rdat_q <= req ? {24'h00_0000, rd_byte} : rdat_q;
         if (wr_lane && hit_tx) tx_ctrl_q <= wb_dat_i[7:0];
         if (wr_lane && hit_rx) rxduty_q  <= wb_dat_i[7:0];
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Field extraction.
   assign ctl = '{tx_sel: tx_ctrl_q[opm_pkg::TXSEL_LO +: 2],
                  tx_mod: tx_ctrl_q[opm_pkg::TXMOD_BIT],
                  tx_inv: tx_ctrl_q[opm_pkg::TXINV_BIT],
                  rx_inv: rxduty_q[opm_pkg::RXINV_BIT],
                  duty:   rxduty_q[opm_pkg::DUTY_LO +: 2]};

   // ==========================================================================
   // Carrier generator
   // ==========================================================================
   logic [15:0] car_cnt_q;
   wire  [15:0] period   = 16'(CARRIER_CYCLES);
   // The shift is three bits wide so that code 11 gives a shift of four, not a wrap to zero.
   wire  [2:0]  duty_sh  = {1'b0, ctl.duty} + 3'd1;
   wire  [15:0] low_len  = period >> duty_sh;
   wire         car_wrap = car_cnt_q == period - 16'd1;

   // Free-running counter of one carrier period.
   always_ff @(posedge clk_i) begin
      if (rst_i) car_cnt_q <= 16'h0000;
      else       car_cnt_q <= car_wrap ? 16'h0000 : car_cnt_q + 16'd1;
   end

   wire car_low = car_cnt_q < low_len;
   wire mod_on  = ctl.tx_mod & sys_power_i & ~brownout_battery_mode_i;

   // ==========================================================================
   // Pin stage
   // ==========================================================================
   logic tx_q;
   logic rx_q;
   wire  tx_pol = uart_tx_i ^ ctl.tx_inv;
   wire  tx_mod = tx_pol & ~(mod_on & car_low);

   // Output and input registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q <= 1'b1;
         rx_q <= 1'b1;
      end else begin
         tx_q <= tx_mod;
         rx_q <= optical_receive_pin_i ^ ctl.rx_inv;
      end
   end
   assign optical_transmit_pin_o    = tx_q;
   assign optical_transmit_active_o = ctl.tx_sel == opm_pkg::TXSEL_SERIAL;
   assign uart_rx_o                 = rx_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
   a_pin_select: assert property (@(posedge clk_i) disable iff (rst_i)
      optical_transmit_active_o == (tx_ctrl_q[3:2] == 2'h0)) else $error("select wrong");
   a_tx_invert: assert property (@(posedge clk_i) disable iff (rst_i)
      !mod_on |=> optical_transmit_pin_o == ($past(uart_tx_i) ^ $past(ctl.tx_inv))) else $error("tx pol");
   a_rx_invert: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> uart_rx_o == ($past(optical_receive_pin_i) ^ $past(ctl.rx_inv))) else $error("rx pol");
   a_carrier_low: assert property (@(posedge clk_i) disable iff (rst_i)
      (mod_on && car_cnt_q == 16'h0000) |=> !optical_transmit_pin_o) else $error("no carrier");
   a_brownout_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (brownout_battery_mode_i && uart_tx_i && !ctl.tx_inv) |=> optical_transmit_pin_o) else $error("brownout mod");
   a_duty_len: assert property (@(posedge clk_i) disable iff (rst_i)
      low_len == ((rxduty_q[5:4] == 2'h0) ? (period >> 1) : (rxduty_q[5:4] == 2'h1) ? (period >> 2) :
                  (rxduty_q[5:4] == 2'h2) ? (period >> 3) : (period >> 4))) else $error("duty length");
   a_duty_high: assert property (@(posedge clk_i) disable iff (rst_i)
      (mod_on && car_cnt_q == period - 16'd1 && uart_tx_i && !ctl.tx_inv) |=> optical_transmit_pin_o)
      else $error("duty high");
   a_period_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      car_wrap |=> car_cnt_q == 16'h0000) else $error("period wrap");

   c_write: cover property (@(posedge clk_i) wb_ack_o && wb_we_i);
   c_modulated: cover property (@(posedge clk_i) mod_on && car_low);
   c_brownout: cover property (@(posedge clk_i) ctl.tx_mod && brownout_battery_mode_i);
   c_duty_min: cover property (@(posedge clk_i) mod_on && ctl.duty == 2'h3);
endmodule
`default_nettype wire

// ===== dv/opm_optic_model.sv
// Phototransistor model that hands a received light level to the receive pin.
`default_nettype none
module opm_optic_model (
   input  wire logic light_i,
   output logic      rx_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // The detector gives a plain level with no carrier filtering.
   assign rx_pin_o = light_i;
endmodule
`default_nettype wire

// ===== dv/opm_top_bench.sv
// Self-checking bench for the optical port modulator.
`default_nettype none
module opm_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, stb, we, ut, pw, bo, lt, rxp, rx_o, tx_o, act, ack;
   logic [17:0] adr;
   logic [31:0] dat, dato, r;
   logic [31:0] exq[$];
   int          fail_count, checks_done, c;
   logic [7:0]  t, d;
   opm_top #(.CARRIER_CYCLES(32)) u_opm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
      .uart_tx_i(ut), .uart_rx_o(rx_o), .sys_power_i(pw), .brownout_battery_mode_i(bo),
      .optical_transmit_pin_o(tx_o), .optical_transmit_active_o(act), .optical_receive_pin_i(rxp));
   opm_optic_model u_opm_optic_model (.light_i(lt), .rx_pin_o(rxp));
   // ==========================================================================
   // Clock, verdict, comparison and bus tasks
   // ==========================================================================
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic test_done;
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
         fail_count++;
      end
   endtask
   task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] v);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, v};
      if (!w) exq.push_back({24'h0, v});
      do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin fail_count++; test_done(); end
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic lows(output int k);
      k = 0;
      repeat (8) @(posedge clk_i);
      repeat (32) begin @(posedge clk_i); k += (tx_o === 1'b0); end
   endtask
   // Read answers are compared with the oldest expectation as they appear.
   always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0 && exq.size() > 0) check(dato, exq.pop_front());
   // ==========================================================================
   // Stimulus
   // ==========================================================================
   initial begin
      {cyc, stb, we, pw, bo, lt} = '0; ut = 1'b1; adr = '0; dat = '0; rst_i = 1'b1;
      void'($urandom(32'hd5838e76));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 18'h09158, 8'h00); wb(0, 18'h0915c, 8'h00); wb(1, 18'h00004, 8'hff); wb(0, 18'h00004, 8'h00);
      // Random pin select, polarity and levels with the carrier off.
      repeat (8) begin
         r = $urandom;
         t = r[7:0] & 8'h0d; d = r[15:8] & 8'h32;
         wb(1, 18'h09158, t); wb(1, 18'h0915c, d); wb(0, 18'h09158, t); wb(0, 18'h0915c, d);
         ut <= r[16]; lt <= r[17];
         repeat (3) @(posedge clk_i);
         check(tx_o, r[16] ^ t[0]);
         check(rx_o, r[17] ^ d[1]);
         check(act, t[3:2] == 2'h0);
      end
      // Each duty code sets the low share of the carrier period.
      ut <= 1'b1; pw <= 1'b1;
      wb(1, 18'h09158, 8'h02);
      for (int k = 0; k < 4; k++) begin
         wb(1, 18'h0915c, 8'(k << 4)); lows(c);
         check(c, 32 >> (k + 1));
      end
      bo <= 1'b1; lows(c);
      check(c, 0);
      bo <= 1'b0; pw <= 1'b0; lows(c);
      check(c, 0);
      test_done();
   end
endmodule
`default_nettype wire
